// ===== hdl/caf_filter_mailbox.v
`include "caf_defines.vh"
`default_nettype none
module caf_filter_mailbox (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [11:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_rx_valid,
  input wire i_rx_ctrl,
  input wire i_rx_ext,
  input wire i_rx_rtr,
  input wire [28:0] i_rx_id,
  input wire [3:0] i_rx_len,
  input wire [63:0] i_rx_data,
  input wire [15:0] i_rx_stamp,
  output reg o_rx_drop
);
  // frame record: ident word, info word, two payload words
  localparam REC_W = 128;
  localparam NB = `CAF_BANKS;
  // control word after reset; reserved bits keep these values on readback
  localparam [31:0] RST_CTL = `CAF_RST_SPLIT_LOCK;

  // configuration registers (first controller holds them all)
  reg [5:0] split_bank_start;
  reg bank_config_unlock;
  reg [NB-1:0] bank_list_select;
  reg [NB-1:0] bank_wide_select;
  reg [NB-1:0] bank_queue_select;
  reg [NB-1:0] bank_active_enable;
  reg [31:0] bank_match_bit [0:2*NB-1];

  // two receive queues, small circular memories
  reg [REC_W-1:0] q0_mem [0:`CAF_QDEPTH-1];
  reg [REC_W-1:0] q1_mem [0:`CAF_QDEPTH-1];
  reg [1:0] q0_rd, q0_wr, q0_cnt;
  reg [1:0] q1_rd, q1_wr, q1_cnt;

  // identifier word as stored in the mailbox
  wire [31:0] rx_ident = i_rx_ext ? {i_rx_id, i_rx_ext, i_rx_rtr, 1'b0}
                                  : {i_rx_id[10:0], 18'h00000, i_rx_ext, i_rx_rtr, 1'b0};
  // payload packing, lowest byte in low lane
  wire [31:0] rx_low = i_rx_data[31:0];
  wire [31:0] rx_high = i_rx_data[63:32];
  // 16-bit view used by half-width filters: std id, rtr, ide, ext[17:15]
  wire [15:0] rx_half = {rx_ident[31:21], i_rx_rtr, i_rx_ext, rx_ident[20:18]};

  // per bank match evaluation
  wire [NB-1:0] bank_hit;
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bank
      wire [31:0] w0 = bank_match_bit[2*g];
      wire [31:0] w1 = bank_match_bit[2*g+1];
      // mask mode compares under mask, list mode compares exact
      wire full_hit = bank_list_select[g] ? (rx_ident == w0 || rx_ident == w1)
                                           : (((rx_ident ^ w0) & w1) == 32'h00000000);
      wire half_hit = bank_list_select[g] ?
        (rx_half == w0[15:0] || rx_half == w0[31:16] || rx_half == w1[15:0] || rx_half == w1[31:16]) :
        ((((rx_half ^ w0[15:0]) & w0[31:16]) == 16'h0000) ||
         (((rx_half ^ w1[15:0]) & w1[31:16]) == 16'h0000));
      // ownership by split point
      wire owned = i_rx_ctrl ? (g >= split_bank_start) : (g < split_bank_start);
      // scale picks 32-bit filters (one in mask mode, two in list mode) or pairs of 16-bit filters
      assign bank_hit[g] = bank_active_enable[g] & owned &
                           (bank_wide_select[g] ? full_hit : half_hit);
    end
  endgenerate

  // lowest numbered hitting bank wins
  reg [7:0] hit_num;
  reg hit_any;
  integer k;
  always @* begin
    hit_num = 8'h00;
    hit_any = 1'b0;
    for (k = NB - 1; k >= 0; k = k - 1) begin
      if (bank_hit[k]) begin
        hit_num = k[7:0];
        hit_any = 1'b1;
      end
    end
  end

  // route of the chosen bank
  wire hit_q1 = bank_queue_select[hit_num[4:0]];
  // info word: stamp, bank number, length
  wire [31:0] rx_info = {i_rx_stamp, hit_num, 4'h0, i_rx_len};
  wire [REC_W-1:0] rx_rec = {rx_high, rx_low, rx_info, rx_ident};

  // pops requested by software
  wire is_wr = i_wr;
  wire pop0 = is_wr && i_addr == `CAF_OFS_RX0_POP && q0_cnt != 2'd0;
  wire pop1 = is_wr && i_addr == `CAF_OFS_RX1_POP && q1_cnt != 2'd0;
  wire push0 = i_rx_valid && hit_any && !hit_q1 && (q0_cnt != `CAF_QDEPTH || pop0);
  wire push1 = i_rx_valid && hit_any && hit_q1 && (q1_cnt != `CAF_QDEPTH || pop1);

  // pointer bump wrapping at depth
  function [1:0] bump;
    input [1:0] p;
    begin
      bump = (p == `CAF_QDEPTH - 1) ? 2'd0 : p + 2'd1;
    end
  endfunction

  // queue storage and pointers; full queue loses the new frame unless it is popped in the same cycle
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q0_rd <= 2'd0;
      q0_wr <= 2'd0;
      q0_cnt <= 2'd0;
      q1_rd <= 2'd0;
      q1_wr <= 2'd0;
      q1_cnt <= 2'd0;
      o_rx_drop <= 1'b0;
    end else begin
      // unmatched frame is flagged and not stored
      o_rx_drop <= i_rx_valid && !hit_any;
      if (push0) begin
        q0_wr <= bump(q0_wr);
      end
      if (pop0) begin
        q0_rd <= bump(q0_rd);
      end
      q0_cnt <= q0_cnt + {1'b0, push0} - {1'b0, pop0};
      if (push1) begin
        q1_wr <= bump(q1_wr);
      end
      if (pop1) begin
        q1_rd <= bump(q1_rd);
      end
      q1_cnt <= q1_cnt + {1'b0, push1} - {1'b0, pop1};
    end
  end

  // queue memories, no reset needed for payload
  always @(posedge i_clk_sys) begin
    if (push0) begin
      q0_mem[q0_wr] <= rx_rec;
    end
    if (push1) begin
      q1_mem[q1_wr] <= rx_rec;
    end
  end

  // decode of bank word window
  wire in_words = i_addr >= `CAF_OFS_WORDS && i_addr <= `CAF_OFS_WORDS_END && i_addr[1:0] == 2'b00;
  wire [11:0] word_ofs = i_addr - `CAF_OFS_WORDS;
  wire [5:0] word_idx = word_ofs[7:2];

  // configuration writes; word access assumed
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      split_bank_start <= RST_CTL[`CAF_SPLIT_MSB:`CAF_SPLIT_LSB];
      bank_config_unlock <= RST_CTL[`CAF_UNLOCK_BIT];
      bank_list_select <= `CAF_RST_BANK_BITS;
      bank_wide_select <= `CAF_RST_BANK_BITS;
      bank_queue_select <= `CAF_RST_BANK_BITS;
      bank_active_enable <= `CAF_RST_BANK_BITS;
    end else if (is_wr) begin
      case (i_addr)
        `CAF_OFS_SPLIT_LOCK: begin
          split_bank_start <= i_wdata[`CAF_SPLIT_MSB:`CAF_SPLIT_LSB];
          bank_config_unlock <= i_wdata[`CAF_UNLOCK_BIT];
        end
        // guarded by the unlock bit
        `CAF_OFS_MATCH_STYLE: begin
          if (bank_config_unlock) begin
            bank_list_select <= i_wdata[NB-1:0];
          end
        end
        `CAF_OFS_WIDTH_SEL: begin
          if (bank_config_unlock) begin
            bank_wide_select <= i_wdata[NB-1:0];
          end
        end
        `CAF_OFS_QUEUE_ROUTE: begin
          if (bank_config_unlock) begin
            bank_queue_select <= i_wdata[NB-1:0];
          end
        end
        // enable is not lock guarded
        `CAF_OFS_ACTIVE: begin
          bank_active_enable <= i_wdata[NB-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // bank data words, undefined at reset
  always @(posedge i_clk_sys) begin
    if (is_wr && in_words) begin
      bank_match_bit[word_idx] <= i_wdata;
    end
  end

  // head records of each queue
  wire [REC_W-1:0] h0 = q0_mem[q0_rd];
  wire [REC_W-1:0] h1 = q1_mem[q1_rd];

  // read mux, registered one cycle; unmapped reads zero
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      if (in_words) begin
        o_rdata <= bank_match_bit[word_idx];
      end else begin
        case (i_addr)
          `CAF_OFS_RX0_IDENT: o_rdata <= h0[31:0];
          `CAF_OFS_RX0_INFO: o_rdata <= h0[63:32];
          `CAF_OFS_RX0_LOW: o_rdata <= h0[95:64];
          `CAF_OFS_RX0_HIGH: o_rdata <= h0[127:96];
          `CAF_OFS_RX1_IDENT: o_rdata <= h1[31:0];
          `CAF_OFS_RX1_INFO: o_rdata <= h1[63:32];
          `CAF_OFS_RX1_LOW: o_rdata <= h1[95:64];
          `CAF_OFS_RX1_HIGH: o_rdata <= h1[127:96];
          `CAF_OFS_RX_STATUS: o_rdata <= {28'h0000000, q1_cnt, q0_cnt};
          `CAF_OFS_SPLIT_LOCK: o_rdata <= {RST_CTL[31:14], split_bank_start, RST_CTL[7:1], bank_config_unlock};
          `CAF_OFS_MATCH_STYLE: o_rdata <= {4'h0, bank_list_select};
          `CAF_OFS_WIDTH_SEL: o_rdata <= {4'h0, bank_wide_select};
          `CAF_OFS_QUEUE_ROUTE: o_rdata <= {4'h0, bank_queue_select};
          `CAF_OFS_ACTIVE: o_rdata <= {4'h0, bank_active_enable};
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/caf_defines.vh
`ifndef CAF_DEFINES_VH
`define CAF_DEFINES_VH
// register byte offsets
`define CAF_OFS_RX0_IDENT 12'h1B0
`define CAF_OFS_RX0_INFO 12'h1B4
`define CAF_OFS_RX0_LOW 12'h1B8
`define CAF_OFS_RX0_HIGH 12'h1BC
`define CAF_OFS_RX1_IDENT 12'h1C0
`define CAF_OFS_RX1_INFO 12'h1C4
`define CAF_OFS_RX1_LOW 12'h1C8
`define CAF_OFS_RX1_HIGH 12'h1CC
`define CAF_OFS_SPLIT_LOCK 12'h200
`define CAF_OFS_MATCH_STYLE 12'h204
`define CAF_OFS_WIDTH_SEL 12'h20C
`define CAF_OFS_QUEUE_ROUTE 12'h214
`define CAF_OFS_ACTIVE 12'h21C
`define CAF_OFS_WORDS 12'h240
`define CAF_OFS_WORDS_END 12'h31C
`define CAF_OFS_RX0_POP 12'h1D0
`define CAF_OFS_RX1_POP 12'h1D4
`define CAF_OFS_RX_STATUS 12'h1D8
// field positions
`define CAF_SPLIT_MSB 13
`define CAF_SPLIT_LSB 8
`define CAF_UNLOCK_BIT 0
`define CAF_BANKS 28
// reset values
`define CAF_RST_SPLIT_LOCK 32'h2A1C0E01
`define CAF_RST_BANK_BITS 28'h0000000
// fifo depth per queue
`define CAF_QDEPTH 3
`endif

// ===== bench/caf_assertions.sv
`default_nettype none
module caf_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_rx_valid,
  input wire logic o_rx_drop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic unlock; // shadow of the lock release bit
  logic [27:0] mode; // shadow of the guarded style bits
  // track writes so a locked write can be judged
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlock <= 1'b1;
      mode <= 28'h0;
    end else if (i_wr) begin
      if (i_addr == 12'h200) unlock <= i_wdata[0];
      if (i_addr == 12'h204 && unlock) mode <= i_wdata[27:0];
    end
  end
  property p_idle_zero; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside read slot");
  property p_info_rsvd; $past(i_rd && (i_addr == 12'h1B4 || i_addr == 12'h1C4)) |-> o_rdata[7:4] == 4'h0; endproperty
  a_info_rsvd: assert property (p_info_rsvd) else $error("info reserved bits set");
  property p_info_bank; $past(i_rd && (i_addr == 12'h1B4 || i_addr == 12'h1C4)) |-> o_rdata[15:8] < 8'h1C; endproperty
  a_info_bank: assert property (p_info_bank) else $error("bank index out of range");
  property p_ident_rsvd; $past(i_rd && (i_addr == 12'h1B0 || i_addr == 12'h1C0)) |-> !o_rdata[0]; endproperty
  a_ident_rsvd: assert property (p_ident_rsvd) else $error("ident bit 0 set");
  property p_ctrl_rsvd; $past(i_rd && i_addr == 12'h200) |-> o_rdata[31:14] == 18'h0A870 && o_rdata[7:1] == 7'h0; endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
  property p_bank_rsvd; $past(i_rd && i_addr[11:4] == 8'h21 && i_addr[1:0] == 2'h0) |-> o_rdata[31:28] == 4'h0; endproperty
  a_bank_rsvd: assert property (p_bank_rsvd) else $error("bank register top bits set");
  property p_mode_lock; $past(i_rd && i_addr == 12'h204) |-> o_rdata[27:0] == mode; endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("style bits changed while locked");
  property p_drop_cause; o_rx_drop |-> $past(i_rx_valid); endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop without a frame");
endmodule
bind caf_filter_mailbox caf_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid), .o_rx_drop(o_rx_drop));
`default_nettype wire

// ===== bench/caf_can_node.sv
`default_nettype none
module caf_can_node (
  input wire logic i_clk_sys,
  output logic o_valid,
  output logic o_ctrl,
  output logic o_ext,
  output logic o_rtr,
  output logic [28:0] o_id,
  output logic [3:0] o_len,
  output logic [63:0] o_data,
  output logic [15:0] o_stamp
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus, nothing offered
  initial begin
    o_valid = 1'b0;
    {o_ctrl, o_ext, o_rtr, o_id, o_len, o_data, o_stamp} = '0;
  end
  // one extended remote frame for one cycle; fields then inverted so stale use shows
  task automatic send(input logic c, input logic [28:0] id, input logic [3:0] n, input logic [63:0] d,
    input logic [15:0] ts);
    @(posedge i_clk_sys);
    o_valid <= 1'b1;
    {o_ctrl, o_ext, o_rtr, o_id, o_len, o_data, o_stamp} <= {c, 2'b11, id, n, d, ts};
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    {o_ctrl, o_ext, o_rtr, o_id, o_len, o_data, o_stamp} <= ~{c, 2'b11, id, n, d, ts};
  endtask
endmodule
`default_nettype wire

// ===== bench/caf_filter_mailbox_tb_top.sv
`default_nettype none
module caf_filter_mailbox_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_rst_n, i_wr, i_rd, o_rx_drop, rx_valid, rx_ctrl, rx_ext, rx_rtr;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [28:0] rx_id;
  logic [3:0] rx_len;
  logic [63:0] rx_data;
  logic [15:0] rx_stamp;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam logic [28:0] fid = 29'h0ABCDEF5; // identifier the filter passes
  logic [11:0] bank_regs [4] = '{12'h204, 12'h20C, 12'h214, 12'h21C};
  caf_filter_mailbox u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(rx_valid), .i_rx_ctrl(rx_ctrl), .i_rx_ext(rx_ext),
    .i_rx_rtr(rx_rtr), .i_rx_id(rx_id), .i_rx_len(rx_len), .i_rx_data(rx_data), .i_rx_stamp(rx_stamp),
    .o_rx_drop(o_rx_drop));
  caf_can_node u_node (.i_clk_sys(i_clk_sys), .o_valid(rx_valid), .o_ctrl(rx_ctrl), .o_ext(rx_ext),
    .o_rtr(rx_rtr), .o_id(rx_id), .o_len(rx_len), .o_data(rx_data), .o_stamp(rx_stamp));
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // full word write, one strobe cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // read data lives only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic frame(input logic c, input logic [28:0] id, input logic drop);
    u_node.send(c, id, 4'h8, 64'h8877665544332211, 16'h5A3C);
    #1;
    chk({31'h0, o_rx_drop}, {31'h0, drop});
  endtask
  task automatic t_reset();
    rd(12'h200, 32'h2A1C0E01);
    foreach (bank_regs[i]) rd(bank_regs[i], 32'h0);
    rd(12'h3F0, 32'h0);
  endtask
  task automatic t_lock();
    wr(12'h200, 32'h00000E00);
    foreach (bank_regs[i]) wr(bank_regs[i], 32'h0000000F);
    rd(12'h204, 32'h0);
    rd(12'h20C, 32'h0);
    rd(12'h214, 32'h0);
    rd(12'h21C, 32'h0000000F);
    wr(12'h21C, 32'h00000008);
    wr(12'h200, 32'h00000E01);
    wr(12'h204, 32'h0FFFFFFF);
    rd(12'h204, 32'h0FFFFFFF);
    wr(12'h204, 32'h0);
  endtask
  task automatic t_frame();
    wr(12'h20C, 32'h00000008);
    wr(12'h214, 32'h00000008);
    wr(12'h258, {fid, 3'b110});
    wr(12'h25C, 32'hFFFFFFFE);
    rd(12'h258, {fid, 3'b110});
    frame(1'b0, fid, 1'b0);
    rd(12'h1C0, {fid, 3'b110});
    rd(12'h1C4, 32'h5A3C0308);
    rd(12'h1C8, 32'h44332211);
    rd(12'h1CC, 32'h88776655);
    rd(12'h1D8, 32'h00000004);
    wr(12'h1D4, 32'h0);
    frame(1'b0, fid ^ 29'h1, 1'b1);
  endtask
  task automatic t_split();
    wr(12'h200, 32'h00000301);
    frame(1'b0, fid, 1'b1);
    frame(1'b1, fid, 1'b0);
    rd(12'h1C4, 32'h5A3C0308);
    wr(12'h200, 32'h00001C01);
    frame(1'b1, fid, 1'b1);
    wr(12'h200, 32'h00000E01);
    wr(12'h21C, 32'h0);
    frame(1'b0, fid, 1'b1);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // hang guard, far above the roughly ninety cycles needed
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h0;
    i_wdata = 32'h0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_frame();
    t_split();
    summarize();
  end
endmodule
`default_nettype wire
